/* File: inc/cfep_pkg.sv */
package cfep_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W   = 21;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int DM_AW  = 12;
  localparam int SP_W   = 5;

  // ----------------------------------------------------------------
  // Reset values and fixed steps
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]   PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0]   PC_STEP  = 21'h000002;
  localparam logic [WORD_W-1:0] NOP_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Instruction fields and opcodes (top nibble)
  // ----------------------------------------------------------------
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int REL_MSB = 10;
  localparam int ACC_BIT = 7;
  localparam logic [3:0] OP_LIT_TO_W    = 4'h1;
  localparam logic [3:0] OP_LATCH_TO_W  = 4'h4;
  localparam logic [3:0] OP_TAB_PTR     = 4'h5;
  localparam logic [3:0] OP_TAB_XFER    = 4'h6;
  localparam logic [3:0] OP_ADD_W_FILE  = 4'h8;
  localparam logic [3:0] OP_RETURN_LIT  = 4'h9;
  localparam logic [3:0] OP_TEST_SKIP   = 4'ha;
  localparam logic [3:0] OP_BRANCH_REL  = 4'hb;
  localparam logic [3:0] OP_MOVE_FILE   = 4'hc;
  localparam logic [3:0] OP_CALL_ABS    = 4'hd;
  localparam logic [3:0] OP_JUMP_ABS    = 4'he;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;

  // ----------------------------------------------------------------
  // Data memory map
  // ----------------------------------------------------------------
  localparam logic [3:0]       ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0]       ACCESS_LO_BANK = 4'h0;
  localparam logic [DM_AW-1:0] PC_LOW_FILE    = 12'hff9;

  // ----------------------------------------------------------------
  // Instruction cycle phases, Gray coded
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR  = 2'b10
  } cfep_phase_t;

  localparam cfep_phase_t PHASE_RESET = PH_FOUR;

endpackage : cfep_pkg

/* File: inc/cfep_phase_if.sv */
interface cfep_phase_if;
  logic phase_one;
  logic phase_two;
  logic phase_three;
  logic phase_four;
  modport gen (output phase_one, phase_two, phase_three, phase_four);
  modport sink (input phase_one, phase_two, phase_three, phase_four);
endinterface : cfep_phase_if

/* File: design/cfep_phase_gen.sv */
module cfep_phase_gen
  import cfep_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst_n,
  cfep_phase_if.gen  ph
);

  typedef struct packed {
    cfep_phase_t phase;
    logic [3:0]  hot;
  } cfep_gen_state_t;

  cfep_gen_state_t s_r;
  cfep_gen_state_t s_nxt;

  // ----------------------------------------------------------------
  // Divide by four into one-hot phase marks
  // ----------------------------------------------------------------
  // Each mark is one clock wide, so phases never overlap.
  always_comb begin
    s_nxt = s_r;
    case (s_r.phase)
      PH_ONE:   s_nxt.phase = PH_TWO;
      PH_TWO:   s_nxt.phase = PH_THREE;
      PH_THREE: s_nxt.phase = PH_FOUR;
      default:  s_nxt.phase = PH_ONE;
    endcase
    case (s_nxt.phase)
      PH_ONE:   s_nxt.hot = 4'h1;
      PH_TWO:   s_nxt.hot = 4'h2;
      PH_THREE: s_nxt.hot = 4'h4;
      default:  s_nxt.hot = 4'h8;
    endcase
  end

  // Reset parks in phase four so the first cycle after release is one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{phase: PHASE_RESET, hot: 4'h8};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ph.phase_one   = s_r.hot[0];
  assign ph.phase_two   = s_r.hot[1];
  assign ph.phase_three = s_r.hot[2];
  assign ph.phase_four  = s_r.hot[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_rotation;
    ph.phase_two ##1 ph.phase_three ##1 ph.phase_four ##1 ph.phase_one;
  endsequence

  chk_phase_rotation: assert property (
    @(posedge clk) disable iff (!rst_n)
    ph.phase_one |=> s_rotation and $onehot(s_r.hot))
    else $error("Phase marks do not rotate one to four.");

endmodule : cfep_phase_gen

/* File: design/cfep_core.sv */
module cfep_core
  import cfep_pkg::*;
#(
  parameter int STACK_DEPTH = 31
)(
  input  wire logic              REF_CLK,
  input  wire logic              RSTN,
  output logic [PC_W-1:0]        PM_ADDR,
  output logic                   PM_RD,
  input  wire logic [WORD_W-1:0] PM_RDATA,
  output logic [DM_AW-1:0]       DM_ADDR,
  output logic                   DM_RD,
  output logic                   DM_WR,
  output logic [DATA_W-1:0]      DM_WDATA,
  input  wire logic [DATA_W-1:0] DM_RDATA,
  output logic [PC_W-1:0]        TB_ADDR,
  output logic                   TB_RD,
  output logic                   TB_WR,
  output logic [DATA_W-1:0]      TB_WDATA,
  input  wire logic [DATA_W-1:0] TB_RDATA,
  output logic [DATA_W-1:0]      WORKING_REGISTER,
  output logic [WORD_W-1:0]      INSTRUCTION_REGISTER,
  output logic [PC_W-1:0]        PROGRAM_COUNTER
);

  if (STACK_DEPTH < 1 || STACK_DEPTH > 31) begin : g_depth_check
    $error("STACK_DEPTH must lie in 1..31.");
  end

  localparam logic [SP_W-1:0] STACK_TOP = SP_W'(STACK_DEPTH);

  typedef struct packed {
    logic [PC_W-1:0]                   pc;
    logic [PC_W-1:0]                   fetch_pc;
    logic [WORD_W-1:0]                 fetch_word;
    logic                              fetch_valid;
    logic [WORD_W-1:0]                 instr;
    logic                              instr_valid;
    logic [PC_W-1:0]                   instr_next_pc;
    logic                              second_pending;
    logic [DATA_W-1:0]                 operand;
    logic [DATA_W-1:0]                 work_reg;
    logic [PC_W-1:0]                   tab_ptr;
    logic [DATA_W-1:0]                 tab_latch;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
    logic [SP_W-1:0]                   sp;
    logic                              pm_rd;
    logic [DM_AW-1:0]                  dm_addr;
    logic                              dm_rd;
    logic                              dm_wr;
    logic [DATA_W-1:0]                 dm_wdata;
    logic                              tb_rd;
    logic                              tb_wr;
  } cfep_core_state_t;

  cfep_core_state_t s_r;
  cfep_core_state_t s_nxt;

  cfep_phase_if ph ();

  cfep_phase_gen u_phase (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ph    (ph.gen)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // In phase one the decode looks at the word about to be loaded, so
  // the phase-two read strobe can leave a flip-flop on time.
  logic [WORD_W-1:0] load_word;
  logic [WORD_W-1:0] cur_instr;
  logic [3:0]        op;
  logic [DM_AW-1:0]  file_addr;
  logic [DM_AW-1:0]  src_addr;
  logic              is_pc_low;
  logic              reads_file;
  logic [PC_W-1:0]   rel_off;
  logic [PC_W-1:0]   abs_target;
  logic [PC_W-1:0]   ret_addr;
  logic [DATA_W-1:0] sum;
  logic              take_branch;
  logic              skip_taken;
  logic              flush;
  logic [PC_W-1:0]   target;

  assign load_word = s_r.fetch_valid ? s_r.fetch_word : NOP_WORD;
  assign cur_instr = ph.phase_one ? load_word : s_r.instr;
  assign op        = cur_instr[OPC_MSB:OPC_LSB];
  assign file_addr = cur_instr[ACC_BIT] ?
                     {ACCESS_HI_BANK, cur_instr[7:0]} :
                     {ACCESS_LO_BANK, cur_instr[7:0]};
  assign src_addr  = (op == OP_MOVE_FILE) ? cur_instr[DM_AW-1:0] : file_addr;
  assign is_pc_low = (op == OP_ADD_W_FILE) && (file_addr == PC_LOW_FILE);
  assign reads_file = (op == OP_ADD_W_FILE) || (op == OP_TEST_SKIP) ||
                      (op == OP_MOVE_FILE);
  // Offset counts words, so it is doubled into bytes.
  assign rel_off    = {{(PC_W-REL_MSB-2){s_r.instr[REL_MSB]}},
                       s_r.instr[REL_MSB:0], 1'b0};
  // The second word is on the fetch bus while the first executes.
  assign abs_target = {s_r.instr[7:0], PM_RDATA[DM_AW-1:0], 1'b0};
  assign ret_addr   = (s_r.sp == '0) ? PC_RESET :
                      s_r.stack[s_r.sp - 5'h01];
  assign sum        = s_r.work_reg + s_r.operand;

  assign take_branch = ph.phase_four &&
                       ((op == OP_JUMP_ABS) || (op == OP_CALL_ABS) ||
                        (op == OP_BRANCH_REL) || (op == OP_RETURN_LIT) ||
                        is_pc_low);
  assign skip_taken  = ph.phase_four && (op == OP_TEST_SKIP) &&
                       (s_r.operand == '0);
  assign flush       = take_branch || skip_taken;

  // A computed jump keeps bit zero clear even for an odd offset.
  always_comb begin
    case (op)
      OP_JUMP_ABS, OP_CALL_ABS: target = abs_target;
      OP_BRANCH_REL: target = s_r.instr_next_pc + rel_off;
      OP_RETURN_LIT: target = ret_addr;
      default: target = {s_r.instr_next_pc[PC_W-1:8], sum[7:1], 1'b0};
    endcase
  end

  // ----------------------------------------------------------------
  // Pipeline sequencing
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.dm_rd = 1'b0;
    s_nxt.dm_wr = 1'b0;
    s_nxt.tb_rd = 1'b0;
    s_nxt.tb_wr = 1'b0;
    if (ph.phase_one) begin
      s_nxt.instr         = load_word;
      s_nxt.instr_valid   = s_r.fetch_valid;
      s_nxt.instr_next_pc = s_r.fetch_pc + PC_STEP;
      s_nxt.fetch_pc      = s_r.pc;
      s_nxt.pc            = s_r.pc + PC_STEP;
      s_nxt.pm_rd         = 1'b1;
      if (reads_file) begin
        s_nxt.dm_rd   = 1'b1;
        s_nxt.dm_addr = src_addr;
      end
      s_nxt.tb_rd = (op == OP_TAB_XFER) && !cur_instr[0];
    end
    if (ph.phase_three) begin
      if (reads_file) begin
        s_nxt.operand = is_pc_low ? s_r.instr_next_pc[7:0] : DM_RDATA;
      end
      if ((op == OP_ADD_W_FILE) && !is_pc_low) begin
        s_nxt.dm_wr    = 1'b1;
        s_nxt.dm_addr  = file_addr;
        s_nxt.dm_wdata = s_r.work_reg + DM_RDATA;
      end
      // Literal of the second word is the destination address.
      if ((op == OP_SECOND_WORD) && s_r.second_pending) begin
        s_nxt.dm_wr    = 1'b1;
        s_nxt.dm_addr  = s_r.instr[DM_AW-1:0];
        s_nxt.dm_wdata = s_r.operand;
      end
      if (op == OP_TAB_XFER) begin
        if (cur_instr[0]) begin
          s_nxt.tb_wr = 1'b1;
        end else begin
          s_nxt.tab_latch = TB_RDATA;
        end
      end
    end
    if (ph.phase_four) begin
      s_nxt.fetch_word  = PM_RDATA;
      s_nxt.fetch_valid = s_r.pm_rd && !flush;
      s_nxt.pm_rd       = 1'b0;
      // A lone second word finds no pending flag and does nothing.
      s_nxt.second_pending = (op == OP_MOVE_FILE);
      if (take_branch) begin
        s_nxt.pc = target;
      end
      case (op)
        OP_LIT_TO_W:   s_nxt.work_reg = s_r.instr[7:0];
        OP_LATCH_TO_W: s_nxt.work_reg = s_r.tab_latch;
        OP_TAB_PTR: begin
          case (s_r.instr[9:8])
            2'h0:    s_nxt.tab_ptr[7:0]   = s_r.instr[7:0];
            2'h1:    s_nxt.tab_ptr[15:8]  = s_r.instr[7:0];
            default: s_nxt.tab_ptr[20:16] = s_r.instr[4:0];
          endcase
        end
        OP_ADD_W_FILE: begin
          if (is_pc_low) begin
            s_nxt.work_reg = s_r.work_reg;
          end
        end
        // Pushes past the top are dropped rather than overwrite it.
        OP_CALL_ABS: begin
          if (s_r.sp < STACK_TOP) begin
            s_nxt.stack[s_r.sp] = s_r.pc;
            s_nxt.sp            = s_r.sp + 5'h01;
          end
        end
        OP_RETURN_LIT: begin
          s_nxt.work_reg = s_r.instr[7:0];
          if (s_r.sp != '0) begin
            s_nxt.sp = s_r.sp - 5'h01;
          end
        end
        default: s_nxt.work_reg = s_r.work_reg;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PM_ADDR              = s_r.fetch_pc;
  assign PM_RD                = s_r.pm_rd;
  assign DM_ADDR              = s_r.dm_addr;
  assign DM_RD                = s_r.dm_rd;
  assign DM_WR                = s_r.dm_wr;
  assign DM_WDATA             = s_r.dm_wdata;
  assign TB_ADDR              = s_r.tab_ptr;
  assign TB_RD                = s_r.tb_rd;
  assign TB_WR                = s_r.tb_wr;
  assign TB_WDATA             = s_r.tab_latch;
  assign WORKING_REGISTER     = s_r.work_reg;
  assign INSTRUCTION_REGISTER = s_r.instr;
  assign PROGRAM_COUNTER      = s_r.pc;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_branch;
    ph.phase_four && take_branch;
  endsequence

  sequence s_bubble;
    !s_r.fetch_valid ##1 !s_r.instr_valid;
  endsequence

  chk_pc_step_one: assert property (
    ph.phase_one |=> s_r.pc == $past(s_r.pc) + PC_STEP)
    else $error("Counter did not advance by two in phase one.");

  chk_pc_lsb_clear: assert property (
    !s_r.pc[0] && !PM_ADDR[0])
    else $error("Counter bit zero is set.");

  chk_fetch_capture: assert property (
    ph.phase_four |=> s_r.fetch_word == $past(PM_RDATA))
    else $error("Fetched word not captured in phase four.");

  chk_instr_load: assert property (
    ph.phase_one |=> ph.phase_two && s_r.instr == $past(load_word))
    else $error("Instruction register not loaded in phase one.");

  chk_dm_read_phase: assert property (
    DM_RD |-> ph.phase_two)
    else $error("Data read outside phase two.");

  chk_dm_write_phase: assert property (
    DM_WR |-> ph.phase_four)
    else $error("Data write outside phase four.");

  chk_fetch_overlap: assert property (
    ph.phase_one |=> PM_RD [*3] ##1 !PM_RD)
    else $error("Fetch strobe not held phases two to four.");

  chk_branch_flush: assert property (
    s_branch |=> s_bubble)
    else $error("Prefetched word not dropped on branch.");

  chk_abs_target: assert property (
    ph.phase_four && op == OP_JUMP_ABS |=>
    s_r.pc == {$past(s_r.instr[7:0]), $past(PM_RDATA[11:0]), 1'b0})
    else $error("Absolute jump target wrong.");

  chk_rel_target: assert property (
    ph.phase_four && op == OP_BRANCH_REL |=>
    s_r.pc == $past(s_r.instr_next_pc) +
    PC_W'(2 * $signed($past(s_r.instr[REL_MSB:0]))))
    else $error("Relative branch target wrong.");

  chk_pair_write: assert property (
    ph.phase_two && op == OP_SECOND_WORD && s_r.second_pending |->
    ##2 DM_WR && DM_ADDR == s_r.instr[11:0])
    else $error("Second word literal not used as destination.");

  chk_lone_second: assert property (
    ph.phase_two && op == OP_SECOND_WORD && !s_r.second_pending |->
    ##2 !DM_WR)
    else $error("Lone second word did not act as no-operation.");

  chk_return_lit: assert property (
    ph.phase_four && op == OP_RETURN_LIT |=>
    WORKING_REGISTER == $past(s_r.instr[7:0]) &&
    s_r.pc == $past(ret_addr))
    else $error("Return with literal wrong.");

  chk_table_read: assert property (
    TB_RD ##1 1'b1 |=> s_r.tab_latch == $past(TB_RDATA))
    else $error("Table latch did not take the read byte.");

endmodule : cfep_core

/* File: verification/cfep_pmem_model.sv */
module cfep_pmem_model
  import cfep_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              slow,
  input  wire logic [PC_W-1:0]   pm_addr,
  input  wire logic              pm_rd,
  output logic      [WORD_W-1:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Word store and read timing
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:255];
  logic [1:0]        age;

  initial begin
    pm_rdata = 16'h0000;
    age      = 2'h0;
  end

  // A released bus toggles so stale data never looks valid; the slow
  // answer appears only in the last cycle the contract allows.
  always @(negedge clk) begin
    if (!pm_rd) begin
      age      <= 2'h0;
      pm_rdata <= ~pm_rdata;
    end else begin
      age <= (age == 2'h3) ? age : age + 2'h1;
      if (slow && age < 2'h2) pm_rdata <= ~pm_rdata;
      else pm_rdata <= mem[pm_addr[8:1]];
    end
  end
endmodule : cfep_pmem_model

/* File: verification/cpu_fetch_execute_pipeline_bench.sv */
module cpu_fetch_execute_pipeline_bench
  import cfep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and logs
  // ----------------------------------------------------------------
  logic              ref_clk = 1'b0;
  logic              rst_n   = 1'b0;
  logic              slow    = 1'b0;
  logic [PC_W-1:0]   pm_addr, tb_addr, pc, tb_a;
  logic              pm_rd, dm_rd, dm_wr, tb_rd, tb_wr;
  logic [WORD_W-1:0] pm_rdata, ir;
  logic [DM_AW-1:0]  dm_addr, wr_a, rd_a;
  logic [DATA_W-1:0] dm_wdata, tb_wdata, w, wr_d, tb_d;
  logic [DATA_W-1:0] dm_rdata = 8'h00;
  logic [DATA_W-1:0] tb_rdata = 8'h00;
  logic [DATA_W-1:0] dm_val   = 8'h00;
  logic [DATA_W-1:0] tb_val   = 8'h00;
  logic              dm_hold  = 1'b0;
  logic              tb_hold  = 1'b0;
  logic              pm_rd_q  = 1'b0;
  logic [255:0]      w_seen;
  logic [PC_W-1:0]   fq [$];
  int err_count, total_checks, cyc, last_f, gap_err, odd;
  int wr_n, wr_dist, rd_c, tb_rn, tb_wn;

  always #12.5 ref_clk = ~ref_clk;

  cfep_core i_dut (
    .REF_CLK(ref_clk), .RSTN(rst_n), .PM_ADDR(pm_addr), .PM_RD(pm_rd),
    .PM_RDATA(pm_rdata), .DM_ADDR(dm_addr), .DM_RD(dm_rd),
    .DM_WR(dm_wr), .DM_WDATA(dm_wdata), .DM_RDATA(dm_rdata),
    .TB_ADDR(tb_addr), .TB_RD(tb_rd), .TB_WR(tb_wr),
    .TB_WDATA(tb_wdata), .TB_RDATA(tb_rdata), .WORKING_REGISTER(w),
    .INSTRUCTION_REGISTER(ir), .PROGRAM_COUNTER(pc)
  );

  cfep_pmem_model i_pmem (
    .clk(ref_clk), .slow(slow), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata)
  );

  // ----------------------------------------------------------------
  // Data and table memory stand-ins plus the bus monitor
  // ----------------------------------------------------------------
  // Read data holds for one cycle after the strobe, then toggles.
  always @(negedge ref_clk) begin
    cyc = cyc + 1;
    if (dm_rd) dm_rdata <= dm_val;
    else if (!dm_hold) dm_rdata <= ~dm_rdata;
    if (tb_rd) tb_rdata <= tb_val;
    else if (!tb_hold) tb_rdata <= ~tb_rdata;
    dm_hold <= dm_rd;
    tb_hold <= tb_rd;
    pm_rd_q <= pm_rd;
    if (rst_n) begin
      w_seen[w] = 1'b1;
      if (pm_addr[0] | pc[0]) odd++;
      if (pm_rd && !pm_rd_q) begin
        fq.push_back(pm_addr);
        if (last_f >= 0 && cyc - last_f != 4) gap_err++;
        last_f = cyc;
      end
      if (dm_rd) begin
        rd_c = cyc;
        rd_a = dm_addr;
      end
      if (dm_wr) begin
        wr_n++;
        wr_a    = dm_addr;
        wr_d    = dm_wdata;
        wr_dist = cyc - rd_c;
      end
      if (tb_rd) begin
        tb_rn++;
        tb_a = tb_addr;
      end
      if (tb_wr) begin
        tb_wn++;
        tb_d = tb_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, seen);
    end
  endtask : chk

  task put(input int a, input logic [WORD_W-1:0] v);
    i_pmem.mem[a/2] = v;
  endtask : put

  // Resets the core, clears program memory and logs; memory answers
  // alternate between prompt and slow from one scenario to the next.
  task start(input logic [DATA_W-1:0] dv);
    @(negedge ref_clk);
    rst_n = 1'b0;
    slow  = ~slow;
    for (int i = 0; i < 256; i++) i_pmem.mem[i] = NOP_WORD;
    fq.delete();
    w_seen  = '0;
    gap_err = 0;
    odd     = 0;
    wr_n    = 0;
    tb_rn   = 0;
    tb_wn   = 0;
    last_f  = -1;
    dm_val  = dv;
    tb_val  = 8'ha5;
    repeat (4) @(negedge ref_clk);
    chk("reset fetch", {31'h0, pm_rd}, 0);
    chk("reset counter", pc, PC_RESET);
  endtask : start

  // Program must end in a branch to itself so the final state settles.
  task go(input int n);
    rst_n = 1'b1;
    repeat (n) @(negedge ref_clk);
    chk("fetch spacing", gap_err, 0);
    chk("odd address", odd, 0);
  endtask : go

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_linear;
    start(8'h00);
    put(0, 16'h1055);
    put(4, 16'h10aa);
    put(6, 16'hb7ff);
    go(60);
    chk("first fetch", fq[0], 0);
    chk("fourth fetch", fq[3], 6);
    chk("w passes 55", w_seen[8'h55], 1);
    chk("w", w, 8'haa);
    chk("ir", ir, 16'hb7ff);
  endtask : t_linear

  task t_jump;
    start(8'h00);
    put(0, 16'he000);
    put(2, 16'hf010);
    put(4, 16'h10bb);
    put(32, 16'h103c);
    put(34, 16'hb7ff);
    go(60);
    chk("jump target fetch", fq[2], 21'h20);
    chk("w", w, 8'h3c);
    chk("flushed word ran", w_seen[8'hbb], 0);
  endtask : t_jump

  task t_branch;
    start(8'h00);
    put(0, 16'hb003);
    put(2, 16'h10bb);
    put(4, 16'h10bb);
    put(6, 16'h10bb);
    put(8, 16'h1077);
    put(10, 16'hb7ff);
    go(60);
    chk("forward target", fq[2], 8);
    chk("backward target", fq[5], 10);
    chk("w", w, 8'h77);
    chk("flushed word ran", w_seen[8'hbb], 0);
  endtask : t_branch

  // A zero operand skips the first word, leaving the second on its own.
  task t_twoword(input logic [DATA_W-1:0] dv);
    start(dv);
    put(0, 16'ha010);
    put(2, 16'hc123);
    put(4, 16'hf456);
    put(6, 16'h1042);
    put(8, 16'hb7ff);
    go(70);
    chk("w", w, 8'h42);
    if (dv == 8'h00) begin
      chk("lone second word", wr_n, 0);
      chk("test source", rd_a, 12'h010);
    end else begin
      chk("move writes", wr_n, 1);
      chk("move source", rd_a, 12'h123);
      chk("move dest", wr_a, 12'h456);
      chk("move data", wr_d, dv);
    end
  endtask : t_twoword

  task t_add;
    start(8'h5a);
    put(0, 16'h1003);
    put(2, 16'h8010);
    put(4, 16'hb7ff);
    go(50);
    chk("add writes", wr_n, 1);
    chk("add dest", wr_a, 12'h010);
    chk("add data", wr_d, 8'h5d);
    chk("read to write gap", wr_dist, 2);
  endtask : t_add

  task t_computed;
    start(8'h00);
    put(0, 16'h1004);
    put(2, 16'hd000);
    put(4, 16'hf040);
    put(6, 16'hb7ff);
    put(128, 16'h80f9);
    put(130, 16'h9011);
    put(132, 16'h9022);
    put(134, 16'h9033);
    go(100);
    chk("returned literal", w, 8'h33);
    chk("skipped entry", w_seen[8'h11] | w_seen[8'h22], 0);
    chk("counter write", wr_n, 0);
  endtask : t_computed

  task t_table;
    start(8'h00);
    put(0, 16'h5012);
    put(2, 16'h5101);
    put(4, 16'h6000);
    put(6, 16'h4000);
    put(8, 16'h6001);
    put(10, 16'hb7ff);
    go(70);
    chk("table reads", tb_rn, 1);
    chk("table addr", tb_a, 21'h000112);
    chk("w", w, 8'ha5);
    chk("table writes", tb_wn, 1);
    chk("table wdata", tb_d, 8'ha5);
  endtask : t_table

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    t_linear();
    t_jump();
    t_branch();
    t_twoword(8'h00);
    t_twoword(8'h5a);
    t_add();
    t_computed();
    t_table();
    summarize();
  end

  // The full run needs about 14.5 us; over three times that means a hang.
  initial begin
    #50000;
    err_count++;
    summarize();
  end
endmodule : cpu_fetch_execute_pipeline_bench
